// [design/spu_pkg.sv]
package spu_pkg;
    localparam int DATA_W = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int DONE_BIT = 7;
    localparam int COLL_BIT = 6;
    localparam int FAULT_BIT = 5;
    localparam int OVRN_BIT = 4;
    localparam int SYNC_N = 3;
    localparam int RX_DEPTH = 2;
    localparam logic [1:0] RX_FULL_COUNT = 2'h2;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam int SEL_LEAD_CLKS = 2;
endpackage

// [design/spu_slave_port.sv]
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: enabled non-master unit acts as slave only
// RULE2: eighth bit sets done flag, stores byte
// RULE3: data read returns receive buffer contents
// RULE4: writes go to transmit buffer, then shifter
// RULE5: busy shifter reloads only after byte end
// RULE6: select modes 0,1 give four-wire slave
// RULE7: four-wire: select low means selected
// RULE8: select falling edge clears bit counter
// RULE9: master leads select by two clocks
// RULE10: select modes 0,0 ignore select line; code still faults an enabled master there on select low
// RULE11: three-wire needs a single slave only
// RULE12: three-wire counter cleared by re-enable only
// RULE13: four sticky flags, software clears, interrupt
// RULE14: done flag set after every byte
// RULE15: write to full buffer flags collision, dropped
// RULE16: multi-master select low faults, disables unit; code checks select for a master only in select modes 0,0
// RULE17: unread buffer: overrun flag, new byte dropped
// RULE18: all phase and polarity combinations supported
// RULE19: master matches phase and polarity
// RULE20: disable unit before changing clock settings
// RULE21: clock rate unused in slave mode
// RULE22: master keeps bit rate within limits
// RULE23: pins synchronised before edge detection
module spu_slave_port (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sclkPin,
    input wire logic mosiPin,
    input wire logic slaveSelectInN,
    output logic misoOut,
    output logic misoOe,
    input wire logic enableWrite,
    input wire logic enableValue,
    input wire logic masterValue,
    output logic unitEnable,
    output logic masterEnable,
    input wire logic selectModeHi,
    input wire logic selectModeLo,
    input wire logic clockPhaseSel,
    input wire logic clockPolaritySel,
    input wire logic txValid,
    input wire logic [spu_pkg::DATA_W-1:0] txData,
    output logic txReady,
    output logic rxValid,
    output logic [spu_pkg::DATA_W-1:0] rxData,
    input wire logic rxReady,
    input wire logic [spu_pkg::DONE_BIT:spu_pkg::OVRN_BIT] flagClear,
    output logic [spu_pkg::DONE_BIT:spu_pkg::OVRN_BIT] statusFlags,
    input wire logic irqEnable,
    output logic irq
);
    logic [spu_pkg::SYNC_N-1:0] pinRaw;
    logic [spu_pkg::SYNC_N-1:0] syncA_q;
    logic [spu_pkg::SYNC_N-1:0] syncB_q;
    logic sclkPrev_q;
    logic nssPrev_q;
    logic unitEnable_q;
    logic masterEnable_q;
    logic [2:0] bitCount_q;
    logic [7:0] shift_q;
    logic shiftFull_q;
    logic outBit_q;
    logic [7:0] txBuf_q;
    logic txFull_q;
    logic [7:0] rxMem_q [spu_pkg::RX_DEPTH];
    logic rxWr_q;
    logic rxRd_q;
    logic [1:0] rxCount_q;
    logic [spu_pkg::DONE_BIT:spu_pkg::OVRN_BIT] flags_q;
    logic [spu_pkg::DONE_BIT:spu_pkg::OVRN_BIT] flagSet;

    assign pinRaw = {sclkPin, slaveSelectInN, mosiPin};

    // every pin passes two flops; only the second stage is read
    genvar gi;
    generate
        for (gi = 0; gi < spu_pkg::SYNC_N; gi++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    syncA_q[gi] <= 1'b1;
                    syncB_q[gi] <= 1'b1;
                end else begin
                    syncA_q[gi] <= pinRaw[gi]; // RULE23
                    syncB_q[gi] <= syncA_q[gi]; // RULE23
                end
            end
        end
    endgenerate

    wire sclkS = syncB_q[2];
    wire nssS = syncB_q[1];
    wire mosiS = syncB_q[0];

    wire fourWire = !selectModeHi && selectModeLo; // RULE6
    wire threeWire = !selectModeHi && !selectModeLo; // RULE10
    // the clock-rate setting only matters for a master; timing here follows the far clock
    wire slaveMode = unitEnable_q && !masterEnable_q; // RULE1 RULE21
    wire selected = slaveMode && (threeWire || (fourWire && !nssS)); // RULE7 RULE10

    wire sclkRise = sclkS && !sclkPrev_q;
    wire sclkFall = !sclkS && sclkPrev_q;
    wire leadEdge = clockPolaritySel ? sclkFall : sclkRise; // RULE18
    wire trailEdge = clockPolaritySel ? sclkRise : sclkFall; // RULE18
    wire sampleEv = selected && (clockPhaseSel ? trailEdge : leadEdge); // RULE18
    wire driveEv = selected && (clockPhaseSel ? leadEdge : trailEdge); // RULE18
    wire nssFall = !nssS && nssPrev_q;
    // in three-wire mode only the enable bit can realign the byte boundary
    wire countClear = !unitEnable_q || (fourWire && nssFall); // RULE8 RULE12
    wire byteDone = sampleEv && (bitCount_q == spu_pkg::BIT_LAST); // RULE2
    wire [7:0] rxByte = {shift_q[6:0], mosiS};

    wire rxFull = (rxCount_q == spu_pkg::RX_FULL_COUNT);
    wire rxPush = byteDone && !rxFull;
    wire rxPop = rxValid && rxReady;
    wire txAccept = txValid && !txFull_q;
    wire collision = txValid && txFull_q; // RULE15
    // loading waits for a byte boundary so a half-shifted receive byte is not corrupted
    wire loadShift = unitEnable_q && txFull_q && !shiftFull_q && (bitCount_q == 3'h0) && !sampleEv; // RULE4 RULE5
    wire modeFault = unitEnable_q && masterEnable_q && threeWire && !nssS; // RULE16

    assign txReady = !txFull_q;
    assign rxValid = (rxCount_q != 2'h0);
    assign rxData = rxMem_q[rxRd_q]; // RULE3
    assign misoOe = selected;
    assign misoOut = outBit_q;
    assign unitEnable = unitEnable_q;
    assign masterEnable = masterEnable_q;
    assign statusFlags = flags_q;
    assign irq = irqEnable && (|flags_q); // RULE13

    assign flagSet[spu_pkg::DONE_BIT] = byteDone; // RULE14
    assign flagSet[spu_pkg::COLL_BIT] = collision; // RULE15
    assign flagSet[spu_pkg::FAULT_BIT] = modeFault; // RULE16
    assign flagSet[spu_pkg::OVRN_BIT] = byteDone && rxFull; // RULE17

    always_ff @(posedge sys_clk) begin
        // same level as the synchroniser reset, so no false clock edge follows reset
        if (sys_rst) begin
            sclkPrev_q <= 1'b1;
            nssPrev_q <= 1'b1;
        end else begin
            sclkPrev_q <= sclkS;
            nssPrev_q <= nssS;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            unitEnable_q <= 1'b0;
            masterEnable_q <= 1'b0;
        end else if (modeFault) begin
            unitEnable_q <= 1'b0; // RULE16
            masterEnable_q <= 1'b0; // RULE16
        end else if (enableWrite) begin
            unitEnable_q <= enableValue;
            masterEnable_q <= masterValue;
        end
    end

    // a set in the same cycle as its clear wins, hardware never clears
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flags_q <= spu_pkg::FLAGS_RESET;
        end else begin
            flags_q <= (flags_q & ~flagClear) | flagSet; // RULE13
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || countClear) begin
            bitCount_q <= 3'h0;
        end else if (sampleEv) begin
            bitCount_q <= bitCount_q + 3'h1; // RULE2
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            shift_q <= spu_pkg::DATA_RESET;
            outBit_q <= 1'b0;
        end else if (loadShift) begin
            shift_q <= txBuf_q; // RULE4
            outBit_q <= txBuf_q[7];
        end else begin
            if (sampleEv) begin
                shift_q <= rxByte;
            end
            if (driveEv) begin
                outBit_q <= shift_q[7];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !unitEnable_q) begin
            shiftFull_q <= 1'b0;
        end else if (loadShift) begin
            shiftFull_q <= 1'b1;
        end else if (byteDone) begin
            shiftFull_q <= 1'b0; // RULE5
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            txBuf_q <= spu_pkg::DATA_RESET;
            txFull_q <= 1'b0;
        end else if (txAccept) begin
            txBuf_q <= txData; // RULE4
            txFull_q <= 1'b1;
        end else if (loadShift) begin
            txFull_q <= 1'b0;
        end
    end

    // two-entry receive buffer; overrun only when both entries are unread
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rxMem_q[0] <= spu_pkg::DATA_RESET;
            rxMem_q[1] <= spu_pkg::DATA_RESET;
            rxWr_q <= 1'b0;
            rxRd_q <= 1'b0;
            rxCount_q <= 2'h0;
        end else begin
            if (rxPush) begin
                rxMem_q[rxWr_q] <= rxByte; // RULE2
                rxWr_q <= !rxWr_q;
            end
            if (rxPop) begin
                rxRd_q <= !rxRd_q;
            end
            rxCount_q <= rxCount_q + {1'b0, rxPush} - {1'b0, rxPop};
        end
    end

    done_sets_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE14
        byteDone |=> flags_q[spu_pkg::DONE_BIT])
        else $error("byte end did not set done flag");

    rx_capture_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
        byteDone && rxCount_q == 2'h0 |=> rxValid && rxData == $past(rxByte))
        else $error("received byte not stored");

    collision_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE15
        txValid && txFull_q && !loadShift |=> flags_q[spu_pkg::COLL_BIT] && $stable(txBuf_q))
        else $error("collision not flagged or write kept");

    tx_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE4
        loadShift |=> shiftFull_q && shift_q == $past(txBuf_q) && outBit_q == $past(txBuf_q[7]))
        else $error("transmit buffer not moved to shifter");

    busy_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
        shiftFull_q && !byteDone && unitEnable_q |=> shiftFull_q)
        else $error("shifter reloaded before byte end");

    overrun_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE17
        byteDone && rxFull && !rxPop |=> flags_q[spu_pkg::OVRN_BIT] && rxCount_q == 2'h2
            && rxData == $past(rxData))
        else $error("overrun not handled");

    fault_disable_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE16
        modeFault |=> !unitEnable && !masterEnable && flags_q[spu_pkg::FAULT_BIT])
        else $error("mode fault did not disable unit");

    select_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
        fourWire && nssFall |=> bitCount_q == 3'h0)
        else $error("select edge did not clear counter");

    deselect_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE7
        fourWire && nssS |-> !misoOe && !sampleEv && !driveEv)
        else $error("deselected slave active");

    flag_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE13
        flags_q[spu_pkg::DONE_BIT] && !flagClear[spu_pkg::DONE_BIT] |=> flags_q[spu_pkg::DONE_BIT])
        else $error("done flag cleared by hardware");

    master_no_shift_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE1
        masterEnable_q |-> !sampleEv && !driveEv && !misoOe)
        else $error("master mode shifted as slave");

    four_wire_sel_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE6
        slaveMode && !selectModeHi && selectModeLo && !nssS |-> misoOe)
        else $error("four-wire slave not selected");

    reenable_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE12
        !unitEnable_q |=> bitCount_q == 3'h0 && !shiftFull_q)
        else $error("disable did not clear bit counter");

    three_wire_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE12
        threeWire && unitEnable_q && !sampleEv |=> $stable(bitCount_q))
        else $error("three-wire counter moved without a bit");

    rx_last_pop_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
        rxPop && !rxPush && rxCount_q == 2'h1 |=> !rxValid)
        else $error("receive buffer not empty after last read");

    irq_raise_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE13
        irqEnable && (|flagSet) |=> irq || !irqEnable)
        else $error("flag set without interrupt");
endmodule

// [testbench/spu_master_model.sv]
`timescale 1ns/1ps
module spu_master_model (
    output logic sclk,
    output logic mosi,
    output logic selN,
    input wire logic miso,
    input wire logic cpol,
    input wire logic cpha
);
    // one byte, msb first; sclk rests at its idle level outside frames
    task automatic xfer(input logic [7:0] txB, input logic useSel, output logic [7:0] rxB);
        sclk = cpol;
        selN = ~useSel;
        mosi = txB[7];
        #50;
        for (int i = 7; i >= 0; i--) begin
            // phase 1 changes data on the leading edge, half a period before it is sampled
            #80 sclk = ~cpol;
            if (cpha) mosi = txB[i];
            else rxB[i] = miso;
            #80 sclk = cpol;
            if (cpha) rxB[i] = miso;
            else if (i > 0) mosi = txB[i-1];
        end
        #80 selN = 1'b1;
        // a released line must not keep showing the last bit
        mosi = ~mosi;
    endtask
    // between frames the clock rests at the level its polarity asks for
    always @(cpol) begin
        if (selN) sclk = cpol;
    end
    initial begin
        sclk = 1'b0;
        mosi = 1'b1;
        selN = 1'b1;
    end
endmodule

// [testbench/spu_slave_port_tb.sv]
`timescale 1ns/1ps
module spu_slave_port_tb;
    logic sys_clk, sys_rst, sclkPin, mosiPin, slaveSelectInN, misoOut, misoOe, misoWire;
    logic enableWrite, enableValue, masterValue, unitEnable, masterEnable, selectModeHi, selectModeLo;
    logic clockPhaseSel, clockPolaritySel, txValid, txReady, rxValid, rxReady, irqEnable, irq;
    logic [7:0] txData, rxData, s, mB, got;
    logic [7:4] flagClear, statusFlags;
    int n_mismatch, n_tests, seed;
    spu_slave_port dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sclkPin(sclkPin), .mosiPin(mosiPin),
        .slaveSelectInN(slaveSelectInN), .misoOut(misoOut), .misoOe(misoOe), .enableWrite(enableWrite),
        .enableValue(enableValue), .masterValue(masterValue), .unitEnable(unitEnable),
        .masterEnable(masterEnable), .selectModeHi(selectModeHi), .selectModeLo(selectModeLo),
        .clockPhaseSel(clockPhaseSel), .clockPolaritySel(clockPolaritySel), .txValid(txValid),
        .txData(txData), .txReady(txReady), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
        .flagClear(flagClear), .statusFlags(statusFlags), .irqEnable(irqEnable), .irq(irq));
    spu_master_model m (.sclk(sclkPin), .mosi(mosiPin), .selN(slaveSelectInN), .miso(misoWire),
        .cpol(clockPolaritySel), .cpha(clockPhaseSel));
    // pull-up holds miso high whenever the slave lets go of it
    assign misoWire = misoOe ? misoOut : 1'b1;
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic setEn(input logic en, input logic ms);
        enableValue = en;
        masterValue = ms;
        enableWrite = 1'b1;
        step(1);
        enableWrite = 1'b0;
        step(1);
    endtask
    task automatic wr(input logic [7:0] d);
        txData = d;
        txValid = 1'b1;
        step(1);
        txValid = 1'b0;
        step(3);
    endtask
    task automatic pop(input logic [7:0] exp);
        check(rxValid, 8'h01);
        check(rxData, exp);
        rxReady = 1'b1;
        step(1);
        rxReady = 1'b0;
        step(1);
    endtask
    task automatic clr();
        flagClear = 4'hf;
        step(1);
        flagClear = 4'h0;
        step(1);
    endtask
    // the done flag lands a few clocks after the last edge, behind the pin synchronisers
    task automatic go(input logic [7:0] b, input logic useSel);
        m.xfer(b, useSel, got);
        step(8);
    endtask
    initial begin
        #200_000;
        n_mismatch++;
        final_report();
    end
    initial begin
        seed = 32'hc2afe75b;
        {sys_rst, enableWrite, enableValue, masterValue, txValid, rxReady, irqEnable} = 7'h40;
        {selectModeHi, selectModeLo, clockPhaseSel, clockPolaritySel} = 4'h4;
        txData = 8'h00;
        flagClear = 4'h0;
        step(16);
        sys_rst = 1'b0;
        check({txReady, rxValid, unitEnable, masterEnable, statusFlags}, 8'h80);
        check({misoOe, irq}, 8'h00);
        check(rxData, 8'h00);
        irqEnable = 1'b1;
        for (int k = 0; k < 4; k++) begin
            setEn(1'b0, 1'b0);
            {clockPolaritySel, clockPhaseSel} = k[1:0];
            setEn(1'b1, 1'b0);
            s = $random(seed);
            mB = $random(seed);
            wr(s);
            go(mB, 1'b1);
            check(got, s);
            check(statusFlags, 8'h08);
            check(irq, 8'h01);
            pop(mB);
            clr();
            $display("clock mode %0d finished", k);
        end
        wr(8'ha5);
        wr(8'h3c);
        check(txReady, 8'h00);
        wr(8'hff);
        check(statusFlags, 8'h04);
        go(8'h11, 1'b1);
        check(got, 8'ha5);
        go(8'h22, 1'b1);
        check(got, 8'h3c);
        go(8'h33, 1'b1);
        check(statusFlags, 8'h0d);
        pop(8'h11);
        pop(8'h22);
        check(rxValid, 8'h00);
        clr();
        $display("collision and overrun finished");
        selectModeHi = 1'b1;
        go(8'h5a, 1'b1);
        check({misoOe, statusFlags}, 8'h00);
        selectModeHi = 1'b0;
        selectModeLo = 1'b0;
        // stray pulses leave a partial count that only a re-enable can clear
        repeat (3) begin
            m.sclk = ~m.sclk;
            step(8);
            m.sclk = ~m.sclk;
            step(8);
        end
        setEn(1'b0, 1'b0);
        setEn(1'b1, 1'b0);
        wr(8'h96);
        go(8'h69, 1'b0);
        check(got, 8'h96);
        pop(8'h69);
        clr();
        $display("select modes finished");
        setEn(1'b1, 1'b1);
        m.selN = 1'b0;
        step(8);
        check({unitEnable, masterEnable, statusFlags}, 8'h02);
        m.selN = 1'b1;
        $display("mode fault finished");
        final_report();
    end
endmodule
